// >>> timer_pkg.sv
// timer_pkg: shared types and constants for the capture/compare/pwm timer
// assumes a single 250 MHz clock domain; no bus, control arrives on plain ports
package timer_pkg;

  localparam int          COUNT_WIDTH     = 16;
  localparam int          MAX_CHANNELS    = 8;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [15:0] COUNT_FULL      = 16'hFFFF;
  localparam logic [15:0] MODULO_RESET    = 16'h0000;
  localparam logic [15:0] VALUE_RESET     = 16'h0000;
  localparam logic [1:0]  EDGE_NONE       = 2'h0;
  localparam logic [1:0]  EDGE_RISE       = 2'h1;
  localparam logic [1:0]  EDGE_FALL       = 2'h2;
  localparam logic [1:0]  EDGE_BOTH       = 2'h3;
  localparam logic [1:0]  CMP_NONE        = 2'h0;
  localparam logic [1:0]  CMP_TOGGLE      = 2'h1;
  localparam logic [1:0]  CMP_LOW         = 2'h2;
  localparam logic [1:0]  CMP_HIGH        = 2'h3;
  localparam logic [1:0]  CLK_OFF         = 2'h0;
  localparam logic [1:0]  CLK_BUS         = 2'h1;
  localparam logic [1:0]  CLK_EXTERNAL    = 2'h3;
  localparam int          SYNC_STAGES     = 2;

  // channel mode select
  typedef enum logic [1:0] {
    CH_CAPTURE,
    CH_COMPARE,
    CH_EDGE_PWM,
    CH_EDGE_PWM_ALT
  } channel_mode_t;

  // per-channel configuration from software
  typedef struct packed {
    channel_mode_t mode;
    logic [1:0]    edge_level_select;
    logic [15:0]   channel_value;
    logic          value_write;
  } channel_cfg_t;

  // per-channel result
  typedef struct packed {
    logic [15:0] captured;
    logic        flag;
  } channel_stat_t;

endpackage : timer_pkg

// >>> edge_sync.sv
// edge_sync: two-stage synchroniser with rise/fall pulse outputs
// assumes pin is asynchronous to clk; first stage feeds only the second
`timescale 1ns/1ps
module edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // pin
  input  wire logic pin,
  // results
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic stage1;
  logic stage2;
  logic stage3;

  // short pulses can slip between samples: two clocks is the safe width
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~stage3;
  assign fall  = ~stage2 & stage3;
endmodule : edge_sync

// >>> timer_capture_compare_pwm.sv
// timer_capture_compare_pwm: 16-bit timer, up to eight capture/compare/pwm channels
// assumes all control inputs are synchronous to clk; pins are split in/out/enable
// Function
// - each channel picks capture, compare or edge pwm
// - one bit forces center pwm on all channels
// - counter pauses during background debug state
// - stop mode halts timer until clocks return
// - wait mode runs exactly like run mode
// - capture edge latches counter, sets channel flag
// - capture edge: rising, falling, both or none
// - compare match sets flag, drives pin action, unless action is none
// - edge pwm period modulo plus one, polarity
// - edge pwm events at period end, match
// - edge pwm leading edges share period start
// - center pwm period twice modulo, duty twice value
// - center mode counts up to modulo, down
// - center pwm active on down match
// - modulo zero or all ones runs free
// - counter readable without disturbing counting
// - any counter byte write resets counter
// - one pin per channel, one to eight
// - 16-bit counter, free or modulo up/down
// - external clock selectable as count source
// - unused channel pin returns to general io
// - after reset no function owns pins
// - edge pwm active at zero, inactive on match
// - capture inputs synchronised, short pulses lost
// - pwm value loads at modulo minus one step
`timescale 1ns/1ps
module timer_capture_compare_pwm #(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // module control
  input  wire logic [1:0]                  clock_select,
  input  wire logic                        center_mode_select,
  input  wire logic                        background_debug_state,
  input  wire logic [15:0]                 counter_modulo_limit,
  input  wire logic                        count_write_low,
  input  wire logic                        count_write_high,
  input  wire logic                        overflow_clear,
  // channel control
  input  wire timer_pkg::channel_cfg_t     channel_cfg [CHANNELS],
  input  wire logic [CHANNELS-1:0]         flag_clear,
  // external clock and pins
  input  wire logic                        external_count_clock,
  input  wire logic [CHANNELS-1:0]         timer_channel_pin_in,
  output logic [CHANNELS-1:0]              timer_channel_pin_out,
  output logic [CHANNELS-1:0]              timer_channel_pin_oe,
  // status
  output logic [15:0]                      timer_count_value,
  output logic                             counting_down,
  output logic                             overflow_flag,
  output logic [CHANNELS-1:0]              duty_event,
  output timer_pkg::channel_stat_t         channel_stat [CHANNELS]
);

  // one pin per channel, and the counter logic below is fixed at sixteen bits
  if (CHANNELS < 1 || CHANNELS > timer_pkg::MAX_CHANNELS) begin : g_bad_channels
    $error("CHANNELS must be 1 to 8");
  end
  if (timer_pkg::COUNT_WIDTH != 16) begin : g_bad_width
    $error("COUNT_WIDTH must be 16");
  end

  // free-running when the limit is zero or all ones
  function automatic logic [15:0] effective_limit(input logic [15:0] lim);
    return (lim == timer_pkg::MODULO_RESET) ? timer_pkg::COUNT_FULL : lim;
  endfunction : effective_limit

  // edge decode against a select code
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    return ((sel == timer_pkg::EDGE_RISE) & r) | ((sel == timer_pkg::EDGE_FALL) & f) |
           ((sel == timer_pkg::EDGE_BOTH) & (r | f));
  endfunction : edge_hit

  // one step either way; wraps at the 16-bit boundary by itself
  function automatic logic [15:0] step_up(input logic [15:0] val);
    return val + 16'h0001;
  endfunction : step_up

  function automatic logic [15:0] step_down(input logic [15:0] val);
    return val - 16'h0001;
  endfunction : step_down

  logic [15:0]         count;
  logic                down;
  logic [15:0]         limit;
  logic                ext_rise;
  logic                tick;
  logic                count_reset;
  logic                at_limit;
  logic                at_zero;
  logic                period_wrap;
  logic                preload_step;
  logic [15:0]         next_count;
  logic                next_down;
  logic [CHANNELS-1:0] pin_level;
  logic [CHANNELS-1:0] pin_rise;
  logic [CHANNELS-1:0] pin_fall;
  logic [15:0]         active_value [CHANNELS];
  logic [15:0]         pending_value [CHANNELS];

  assign limit       = effective_limit(counter_modulo_limit);
  assign count_reset = count_write_low | count_write_high;
  // stop mode removes clk itself, so nothing here needs to model it
  // wait mode has no input at all: the timer simply keeps running
  assign tick = (clock_select == timer_pkg::CLK_BUS
                 || (clock_select == timer_pkg::CLK_EXTERNAL && ext_rise))
                && !background_debug_state;
  // exact match only: a count above a lowered limit runs on to the 16-bit wrap
  assign at_limit     = (count == limit);
  assign at_zero      = (count == timer_pkg::COUNT_RESET);
  assign period_wrap  = tick && !center_mode_select && at_limit;
  assign preload_step = tick && !down && (count == step_down(limit));

  // external clock is sampled by bus clock; must not exceed a quarter rate
  edge_sync ext_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (external_count_clock),
    .level (),
    .rise  (ext_rise),
    .fall  ()
  );

  // counter next state: up-wrap, or up/down in center mode
  always_comb begin
    next_count = count;
    next_down  = down;
    if (center_mode_select) begin
      if (!down) begin
        if (at_limit) begin
          next_down  = 1'b1;
          next_count = step_down(count);
        end else begin
          next_count = step_up(count);
        end
      end else begin
        if (at_zero) begin
          next_down  = 1'b0;
          next_count = step_up(count);
        end else begin
          next_count = step_down(count);
        end
      end
    end else begin
      next_down  = 1'b0;
      next_count = at_limit ? timer_pkg::COUNT_RESET : step_up(count);
    end
  end

  // a count write wins over a tick in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= timer_pkg::COUNT_RESET;
      down  <= 1'b0;
    end else if (count_reset) begin
      count <= timer_pkg::COUNT_RESET;
      down  <= 1'b0;
    end else if (tick) begin
      count <= next_count;
      down  <= next_down;
    end
  end

  // read path is a plain copy: reading never touches the counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_count_value <= timer_pkg::COUNT_RESET;
      counting_down     <= 1'b0;
      overflow_flag     <= 1'b0;
    end else begin
      timer_count_value <= count;
      counting_down     <= down;
      // set wins over clear
      overflow_flag     <= period_wrap | (overflow_flag & ~overflow_clear);
    end
  end

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    logic          enabled;
    logic          is_capture;
    logic          is_compare;
    logic          is_edge_pwm;
    logic          match;
    logic          event_hit;
    logic          pwm_active;
    logic          drive_out;
    logic          next_out;
    logic [1:0]    els;
    // named pin actions and event sources
    logic          capture_hit;
    logic          match_hit;
    logic          center_on;
    logic          center_off;
    logic          edge_on;
    logic          edge_off;

    assign els         = channel_cfg[ch].edge_level_select;
    // none selected leaves the pin to general io
    assign enabled     = (els != timer_pkg::EDGE_NONE) && (clock_select != timer_pkg::CLK_OFF);
    assign is_capture  = !center_mode_select && channel_cfg[ch].mode == timer_pkg::CH_CAPTURE;
    assign is_compare  = !center_mode_select && channel_cfg[ch].mode == timer_pkg::CH_COMPARE;
    assign is_edge_pwm = !center_mode_select && channel_cfg[ch].mode[1];
    // matching the count being entered keeps the pin in step with the counter
    assign match       = tick && !count_reset && (next_count == active_value[ch]);
    assign pwm_active  = ~els[0]; // polarity: high-true unless low bit set

    edge_sync pin_sync (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (timer_channel_pin_in[ch]),
      .level (pin_level[ch]),
      .rise  (pin_rise[ch]),
      .fall  (pin_fall[ch])
    );

    assign capture_hit = is_capture && edge_hit(els, pin_rise[ch], pin_fall[ch]);
    assign match_hit   = !is_capture && enabled && match;
    assign event_hit   = capture_hit | match_hit;

    // center: active entering the value downward, inactive entering it upward
    assign center_on   = center_mode_select && match && next_down;
    assign center_off  = center_mode_select && match && !next_down;
    // edge: the match beats the wrap, so a zero value gives zero duty
    assign edge_off    = is_edge_pwm && match;
    assign edge_on     = is_edge_pwm && period_wrap && !match;

    // output action; toggle starts from the current pin level
    always_comb begin
      next_out = timer_channel_pin_out[ch];
      // an undriven pin starts from the level it shows
      if (!timer_channel_pin_oe[ch])
        next_out = pin_level[ch];
      if (center_on)
        next_out = pwm_active;
      else if (center_off)
        next_out = ~pwm_active;
      else if (edge_on)
        next_out = pwm_active; // leading edges share the wrap
      else if (edge_off)
        next_out = ~pwm_active;
      else if (is_compare && match) begin
        unique case (els)
          timer_pkg::CMP_TOGGLE: next_out = ~next_out;
          timer_pkg::CMP_LOW:    next_out = 1'b0;
          timer_pkg::CMP_HIGH:   next_out = 1'b1;
          timer_pkg::CMP_NONE:   next_out = next_out;
        endcase
      end
    end

    assign drive_out = enabled && !is_capture;

    // pwm values are double-buffered and load at limit-minus-one
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        pending_value[ch] <= timer_pkg::VALUE_RESET;
        active_value[ch]  <= timer_pkg::VALUE_RESET;
      end else begin
        if (channel_cfg[ch].value_write)
          pending_value[ch] <= channel_cfg[ch].channel_value;
        if (!(center_mode_select || is_edge_pwm) || preload_step)
          active_value[ch] <= channel_cfg[ch].value_write ? channel_cfg[ch].channel_value
                                                          : pending_value[ch];
      end
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        // pins and flags change only on the clock, never through logic
        timer_channel_pin_out[ch] <= 1'b0;
        timer_channel_pin_oe[ch]  <= 1'b0;
        duty_event[ch]            <= 1'b0;
        channel_stat[ch]          <= '0;
      end else begin
        timer_channel_pin_out[ch] <= next_out;
        timer_channel_pin_oe[ch]  <= drive_out;
        duty_event[ch]            <= enabled && match && (is_edge_pwm || center_mode_select);
        // capture mode keeps the last latched count until the next edge
        if (is_capture && event_hit)
          channel_stat[ch].captured <= count;
        else if (!is_capture)
          channel_stat[ch].captured <= active_value[ch];
        // a new event beats a simultaneous clear
        channel_stat[ch].flag <= event_hit | (channel_stat[ch].flag & ~flag_clear[ch]);
      end
    end
  end

endmodule : timer_capture_compare_pwm

// >>> timer_pin_model.sv
// pin model: loads and edge sources on the channel pins, plus the external count source
// assumes no pull on the pins; a released pin shows the level this model drives
`timescale 1ns/1ps
module timer_pin_model #(
  parameter int CHANNELS = 2
) (
  // clock
  input  wire logic                clk,
  // timer side
  input  wire logic [CHANNELS-1:0] pin_out,
  input  wire logic [CHANNELS-1:0] pin_oe,
  output logic [CHANNELS-1:0]      pin_in,
  output logic                     ext_clock
);
  logic [CHANNELS-1:0] drive = '0;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
  initial ext_clock = 1'h0;
  // held four cycles, so the synchroniser cannot miss it
  task automatic set_pin(input int ch, input logic lvl);
    drive[ch] = lvl;
    repeat (4) @(negedge clk);
  endtask : set_pin
  // two high, two low: the fastest rate the timer accepts
  task automatic ext_pulses(input int n);
    repeat (n) begin
      ext_clock = 1'h1;
      repeat (2) @(negedge clk);
      ext_clock = 1'h0;
      repeat (2) @(negedge clk);
    end
  endtask : ext_pulses
endmodule : timer_pin_model

// >>> timer_capture_compare_pwm_checker.sv
// checker: timer port assertions, channel 0 watched
// assumes steady checks run from the bus clock
`timescale 1ns/1ps
module timer_capture_compare_pwm_checker #(
  parameter int CHANNELS = 2
) (
  // clock, reset, control
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic [1:0]               clock_select,
  input wire logic                     center_mode_select,
  input wire logic                     background_debug_state,
  input wire logic [15:0]              counter_modulo_limit,
  input wire logic                     count_write_low,
  input wire logic                     count_write_high,
  input wire timer_pkg::channel_cfg_t  channel_cfg [CHANNELS],
  // pins and status
  input wire logic [CHANNELS-1:0]      timer_channel_pin_in,
  input wire logic [CHANNELS-1:0]      timer_channel_pin_out,
  input wire logic [CHANNELS-1:0]      timer_channel_pin_oe,
  input wire logic [15:0]              timer_count_value,
  input wire logic                     overflow_flag,
  input wire timer_pkg::channel_stat_t channel_stat [CHANNELS]
);
  logic        wr, cms, steady, hold, cap;
  logic [3:0]  age;
  logic [15:0] v, ml, lim, cv, nv;
  logic [1:0]  els;
  logic [37:0] snap, snap_q;
  assign wr     = count_write_low | count_write_high;
  assign cms    = center_mode_select;
  assign v      = timer_count_value;
  assign ml     = counter_modulo_limit;
  assign lim    = (ml == 16'h0000) ? 16'hFFFF : ml;
  assign cv     = channel_cfg[0].channel_value;
  // the count copy lags one cycle: nv is where the counter stands now
  assign nv     = (v == lim) ? 16'h0000 : v + 16'h0001;
  assign els    = channel_cfg[0].edge_level_select;
  assign cap    = channel_cfg[0].mode == timer_pkg::CH_CAPTURE;
  assign snap   = {ml, cms, channel_cfg[0]};
  assign steady = clock_select == timer_pkg::CLK_BUS && !background_debug_state && !wr
                  && snap == snap_q;
  assign hold   = steady && age == 4'hF;
  // fifteen quiet cycles cover a pwm value reload
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      age    <= 4'h0;
      snap_q <= '0;
    end else begin
      snap_q <= snap;
      age    <= !steady ? 4'h0 : age + {3'h0, age != 4'hF};
    end
  end
  property p_debug_hold;
    @(posedge clk) disable iff (!rstn)
    (background_debug_state && !wr)[*3] |-> $stable(v);
  endproperty
  a_debug_hold: assert property (p_debug_hold) else $error("count moved while paused");
  property p_up_count;
    @(posedge clk) disable iff (!rstn)
    hold && !cms |-> v == (($past(v) == lim) ? 16'h0000 : $past(v) + 16'h0001);
  endproperty
  a_up_count: assert property (p_up_count) else $error("up count wrong");
  property p_wrap_flag;
    @(posedge clk) disable iff (!rstn)
    hold && !cms && v == lim |-> ##[1:3] overflow_flag;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("no overflow at wrap");
  property p_center_turn;
    @(posedge clk) disable iff (!rstn)
    hold && cms && ml != 16'h0000 && ($past(v) == ml || $past(v) == 16'h0000)
      |-> v == (($past(v) == ml) ? ml - 16'h0001 : 16'h0001);
  endproperty
  a_center_turn: assert property (p_center_turn) else $error("center count turn wrong");
  property p_center_pin;
    @(posedge clk) disable iff (!rstn)
    hold && cms && els == 2'h2 && cv > 16'h0001 && cv < ml && (v == 16'h0000 || v == ml)
      |-> timer_channel_pin_out[0] == (v == 16'h0000);
  endproperty
  a_center_pin: assert property (p_center_pin) else $error("center pulse misplaced");
  property p_edge_pin;
    @(posedge clk) disable iff (!rstn)
    hold && !cms && channel_cfg[0].mode[1] && els == 2'h2 && cv != 16'h0000 && cv <= lim
      |-> timer_channel_pin_oe[0] && timer_channel_pin_out[0] == (nv < cv);
  endproperty
  a_edge_pin: assert property (p_edge_pin) else $error("edge pwm level wrong");
  property p_capture_flag;
    @(posedge clk) disable iff (!rstn)
    $rose(timer_channel_pin_in[0]) && !cms && cap && els == timer_pkg::EDGE_RISE
      |-> ##[1:5] channel_stat[0].flag;
  endproperty
  a_capture_flag: assert property (p_capture_flag) else $error("capture flag missing");
  property p_pin_release;
    @(posedge clk) disable iff (!rstn)
    (els == 2'h0 || (!cms && cap))[*3] |-> !timer_channel_pin_oe[0];
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin not released");
endmodule : timer_capture_compare_pwm_checker
bind timer_capture_compare_pwm timer_capture_compare_pwm_checker #(.CHANNELS(CHANNELS)) chk (
  .clk, .rstn, .clock_select, .center_mode_select, .background_debug_state,
  .counter_modulo_limit, .count_write_low, .count_write_high, .channel_cfg,
  .timer_channel_pin_in, .timer_channel_pin_out, .timer_channel_pin_oe,
  .timer_count_value, .overflow_flag, .channel_stat);

// >>> timer_capture_compare_pwm_bench.sv
// bench: drives the timer through its plain control ports, checks pins and status
// assumes two channels and the pin model on the far side
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module timer_capture_compare_pwm_bench;
  logic                     clk = 1'h0;
  logic                     rstn = 1'h0;
  logic [1:0]               clock_select = timer_pkg::CLK_BUS;
  logic                     center_mode_select = 1'h0;
  logic                     background_debug_state = 1'h0;
  logic [15:0]              counter_modulo_limit = 16'h0000;
  logic                     count_write_low = 1'h0;
  logic                     count_write_high = 1'h0;
  logic                     overflow_clear = 1'h0;
  logic [1:0]               flag_clear = 2'h0;
  timer_pkg::channel_cfg_t  channel_cfg [2];
  logic                     external_count_clock;
  logic [1:0]               pin_in, pin_out, pin_oe;
  logic [15:0]              count;
  logic                     down;
  logic [1:0]               duty;
  logic                     overflow_flag;
  timer_pkg::channel_stat_t stat [2];
  int                       mismatches = 0, check_count = 0, cycles = 0, hi0, hi1, both, ev, dn;
  logic [1:0]               acts [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  logic                     pinx [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
  always #2 clk = ~clk;
  timer_capture_compare_pwm #(.CHANNELS(2)) DUT (
    .clk, .rstn, .clock_select, .center_mode_select, .background_debug_state,
    .counter_modulo_limit, .count_write_low, .count_write_high, .overflow_clear,
    .channel_cfg, .flag_clear, .external_count_clock, .timer_channel_pin_in(pin_in),
    .timer_channel_pin_out(pin_out), .timer_channel_pin_oe(pin_oe), .overflow_flag,
    .timer_count_value(count), .counting_down(down), .duty_event(duty), .channel_stat(stat));
  timer_pin_model #(.CHANNELS(2)) pins (
    .clk, .pin_out, .pin_oe, .pin_in, .ext_clock(external_count_clock));
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic set_ch(input int c, input timer_pkg::channel_mode_t m, input logic [1:0] e,
                        input logic [15:0] val);
    channel_cfg[c] = '{m, e, val, 1'h1};
    tick(1);
    channel_cfg[c].value_write = 1'h0;
  endtask : set_ch
  // counter to zero and flags cleared; shows j-1 after j more ticks
  task automatic restart(input logic lo);
    count_write_low = lo;
    count_write_high = !lo;
    flag_clear = 2'h3;
    overflow_clear = 1'h1;
    tick(1);
    {count_write_low, count_write_high, flag_clear, overflow_clear} = 5'h0;
  endtask : restart
  // settle through two pwm reloads, then count pin-high, duty event and down cycles
  task automatic measure(input int n);
    tick(20);
    hi0 = 0;
    hi1 = 0;
    both = 0;
    ev = 0;
    dn = 0;
    repeat (n) begin
      tick(1);
      hi0 += int'(pin_out[0] === 1'h1);
      hi1 += int'(pin_out[1] === 1'h1);
      both += int'(pin_out === 2'h3);
      ev += int'(duty[0] === 1'h1);
      dn += int'(down === 1'h1);
    end
  endtask : measure
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // a hang counts as a mismatch; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    channel_cfg = '{'0, '0};
    tick(10);
    rstn = 1'h1;
    tick(1);
    `CHK("enables", 2'h0, pin_oe)
    restart(1'h1);
    tick(5);
    `CHK("count", 16'h0004, count)
    restart(1'h0);
    tick(1);
    `CHK("count write", 16'h0000, count)
    tick(1);
    background_debug_state = 1'h1;
    tick(6);
    `CHK("paused count", 16'h0002, count)
    background_debug_state = 1'h0;
    tick(3);
    `CHK("resumed count", 16'h0004, count)
    counter_modulo_limit = 16'h0004;
    restart(1'h1);
    tick(4);
    `CHK("overflow early", 1'h0, overflow_flag)
    tick(2);
    `CHK("overflow", 1'h1, overflow_flag)
    $display("test counter done");
    counter_modulo_limit = 16'h0000;
    for (int e = 0; e < 4; e++) begin
      set_ch(0, timer_pkg::CH_CAPTURE, 2'(e), 16'h0000);
      restart(1'h1);
      pins.set_pin(0, 1'h1);
      tick(2);
      `CHK("rise flag", e[0], stat[0].flag)
      if (e[0]) `CHK("captured", 1'h1, stat[0].captured inside {[1:6]})
      restart(1'h1);
      pins.set_pin(0, 1'h0);
      tick(2);
      `CHK("fall flag", e[1], stat[0].flag)
    end
    $display("test capture done");
    for (int a = 0; a < 4; a++) begin
      set_ch(0, timer_pkg::CH_COMPARE, acts[a], 16'h0006);
      restart(1'h1);
      tick(12);
      `CHK("match flag", a != 3, stat[0].flag)
      `CHK("match pin", pinx[a], pin_out[0] & pin_oe[0])
    end
    $display("test compare done");
    counter_modulo_limit = 16'h0004;
    set_ch(0, timer_pkg::CH_EDGE_PWM, 2'h2, 16'h0002);
    set_ch(1, timer_pkg::CH_EDGE_PWM, 2'h3, 16'h0003);
    restart(1'h1);
    measure(5);
    `CHK("edge high-true", 2, hi0)
    `CHK("edge low-true", 2, hi1)
    `CHK("edge overlap", 0, both)
    `CHK("edge enables", 2'h3, pin_oe)
    `CHK("edge events", 1, ev)
    `CHK("edge direction", 0, dn)
    center_mode_select = 1'h1;
    measure(8);
    `CHK("center high-true", 4, hi0)
    `CHK("center low-true", 2, hi1)
    `CHK("center overlap", 0, both)
    `CHK("center events", 2, ev)
    `CHK("center down", 4, dn)
    center_mode_select = 1'h0;
    set_ch(1, timer_pkg::CH_CAPTURE, 2'h0, 16'h0000);
    tick(3);
    `CHK("released pin", 1'h0, pin_oe[1])
    $display("test pwm done");
    clock_select = timer_pkg::CLK_EXTERNAL;
    counter_modulo_limit = 16'h0000;
    restart(1'h1);
    pins.ext_pulses(5);
    tick(6);
    `CHK("external count", 16'h0005, count)
    $display("test external clock done");
    print_verdict();
  end
endmodule : timer_capture_compare_pwm_bench
